// file: logic/ees_pkg.sv
// Package: constants and carrier types for the serial EEPROM slave
package ees_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int PAGE_BYTES = 16;
  localparam int PAGE_LSB_W = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_MAX = 7;
  localparam logic [3:0] DEV_CODE_RESET = 4'h6; // Arbitrary value, neutral default type code
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [4:0] FILL_ZERO = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 8'h01;
  localparam logic [PAGE_LSB_W-1:0] LOW_ONE = 4'h1;
  // Programming cycle time and its length in clocks
  localparam int PROG_TIME_US = 5000;
  localparam int CLK_MHZ = 40;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int PROG_CNT_W = 18;

  typedef enum {
    EES_IDLE, EES_DEVADR, EES_DEVACK, EES_WADR, EES_WADRACK,
    EES_WDATA, EES_WDACK, EES_RDATA, EES_RACK, EES_WAITSTOP
  } ees_state_t;

  // One buffered page byte: in-page offset and value
  typedef struct packed {
    logic [PAGE_LSB_W-1:0] offs;
    logic [DATA_W-1:0] data;
  } ees_wbyte_t;

  // Serial pin group toward the device
  typedef struct packed {
    logic scl;
    logic sda;
  } ees_bus_t;
endpackage : ees_pkg

// file: logic/ees_fifo.sv
// Parameterised valid/ready FIFO holding buffered page bytes
`timescale 1ns/1ps
`default_nettype none
module ees_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wptr, rptr, next_wptr, next_rptr;
  logic push, pop;

  // Flags from pointer difference; a full FIFO still takes a word when one leaves
  assign in_ready = ((wptr - rptr) != (PW+1)'(DEPTH)) || out_ready;
  assign out_valid = wptr != rptr;
  assign out_data = mem[rptr[PW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer next values
  always_comb begin
    next_wptr = clear ? '0 : wptr + (PW+1)'(push);
    next_rptr = clear ? '0 : rptr + (PW+1)'(pop);
  end

  // Pointer registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else if (ce) begin
      wptr <= next_wptr;
      rptr <= next_rptr;
    end
  end

  // Storage, no reset needed for data
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wptr[PW-1:0]] <= in_data;
    end
  end
endmodule // ees_fifo
`default_nettype wire

// file: logic/ees_slave.sv
// Serial EEPROM slave: bus front end, page buffer, array and write timer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Byte write: address, word address, one data byte, each acknowledged, then STOP.
// - STOP after a write starts programming; all requests ignored until done.
// - Page write takes up to sixteen bytes in one programming cycle.
// - Each acknowledged data byte bumps only the low in-page address bits.
// - Beyond sixteen bytes the in-page address wraps and overwrites earlier bytes.
// - STOP commits all buffered bytes in a single programming cycle.
// - Address is not acknowledged while programming, acknowledged afterwards.
// - Write protect high: addresses acked, first data byte refused, nothing programmed.
// - Direction bit one selects read; current, random and sequential reads supported.
// - Address counter holds last accessed location plus one.
// - Counter rolls from 255 to zero during reads.
// - Each master acknowledge brings the next byte in a sequential read.
// - Read increments the full address counter, covering the whole array.
// - Only the matching four-bit type code in the address byte is acknowledged.
// - Master not acknowledging stops data output; device waits for STOP.
// - Supervisor reset aborts transfers, blocks new ones, lets programming finish.
// - Receiver pulls data low during the ninth clock of each byte it accepts.
module ees_slave #(
  parameter int PROG_CYCLES = ees_pkg::PROG_CYCLES,
  parameter logic [3:0] DEV_CODE = ees_pkg::DEV_CODE_RESET // Arbitrary value
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire ees_pkg::ees_bus_t BUS_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic WP,
  input wire logic SUP_RESET,
  output logic BUSY
);
  logic [ees_pkg::DATA_W-1:0] mem [ees_pkg::MEM_DEPTH];
  ees_pkg::ees_state_t state, next_state;
  logic scl_q, sda_q, scl_rise, scl_fall, start_c, stop_c;
  logic [2:0] bitc, next_bitc;
  logic [7:0] shreg, next_shreg;
  logic [ees_pkg::ADDR_W-1:0] addr, next_addr, page_base, next_page_base;
  logic rw, next_rw, acking, next_acking, wrote, next_wrote;
  logic oe, next_oe;
  logic full, next_full;
  logic [ees_pkg::PAGE_LSB_W:0] fill, next_fill;
  logic [ees_pkg::PROG_CNT_W-1:0] pcnt, next_pcnt;
  logic busy, next_busy, committing, next_committing;
  ees_pkg::ees_wbyte_t fin, fout;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_clear;
  // Buffered byte count limits, one page deep
  localparam logic [ees_pkg::PAGE_LSB_W:0] FILL_FULL = (ees_pkg::PAGE_LSB_W+1)'(ees_pkg::PAGE_BYTES);
  localparam logic [ees_pkg::PAGE_LSB_W:0] FILL_ONE = (ees_pkg::PAGE_LSB_W+1)'(1);

  // Bus conditions from registered copies of the pins
  assign scl_rise = BUS_IN.scl && !scl_q;
  assign scl_fall = !BUS_IN.scl && scl_q;
  assign start_c = BUS_IN.scl && scl_q && sda_q && !BUS_IN.sda;
  assign stop_c = BUS_IN.scl && scl_q && !sda_q && BUS_IN.sda;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (CE) begin
      scl_q <= BUS_IN.scl;
      sda_q <= BUS_IN.sda;
    end
  end

  // Page buffer between bus and array
  ees_fifo #(.WIDTH($bits(ees_pkg::ees_wbyte_t)), .DEPTH(ees_pkg::FIFO_DEPTH)) u_fifo (
    .clk(MCLK),
    .rst_n(RST_N),
    .ce(CE),
    .clear(f_clear),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(fin),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(fout)
  );

  // drain into array while committing; drop the oldest byte when the page is full
  assign f_out_ready = committing || (f_in_valid && fill == FILL_FULL);

  // Protocol engine next state
  always_comb begin
    next_state = state;
    next_bitc = bitc;
    next_shreg = shreg;
    next_addr = addr;
    next_page_base = page_base;
    next_rw = rw;
    next_acking = acking;
    next_wrote = wrote;
    next_oe = oe;
    next_full = full;
    next_fill = fill;
    f_in_valid = 1'b0;
    f_clear = 1'b0;
    fin.offs = addr[ees_pkg::PAGE_LSB_W-1:0];
    fin.data = shreg;
    if (SUP_RESET) begin
      next_state = ees_pkg::EES_IDLE;
      next_oe = 1'b0;
      next_wrote = 1'b0;
      next_acking = 1'b0;
      next_full = 1'b0;
      next_fill = ees_pkg::FILL_ZERO;
      if (!busy) begin
        f_clear = 1'b1;
      end
    end else if (stop_c) begin
      next_state = ees_pkg::EES_IDLE;
      next_oe = 1'b0;
      // Clearing keeps a later STOP, after a poll or read, from programming again
      next_wrote = 1'b0;
      next_full = 1'b0;
      next_fill = ees_pkg::FILL_ZERO;
    end else if (start_c) begin
      // restart the address phase on every START, also while programming; keep bit state clean
      next_state = ees_pkg::EES_DEVADR;
      next_bitc = ees_pkg::BIT_FIRST;
      next_full = 1'b0;
      next_oe = 1'b0;
    end else begin
      case (state)
        ees_pkg::EES_DEVADR, ees_pkg::EES_WADR, ees_pkg::EES_WDATA: begin
          // sample on rising edge, MSB first; rises are counted
          if (scl_rise) begin
            next_shreg = {shreg[6:0], BUS_IN.sda};
            next_bitc = bitc + 3'h1;
            next_full = bitc == ees_pkg::BIT_LAST;
          end
          // Decide on the fall after the eighth rise; the fall after START carries no bit
          if (scl_fall && full) begin
            next_full = 1'b0;
            next_bitc = ees_pkg::BIT_FIRST;
            next_acking = 1'b1;
            case (state)
              ees_pkg::EES_DEVADR: begin
                // type code must match and no programming running
                next_acking = shreg[7:4] == DEV_CODE && !busy;
                next_rw = shreg[0];
                next_state = ees_pkg::EES_DEVACK;
              end
              ees_pkg::EES_WADR: begin
                next_addr = shreg;
                next_page_base = shreg;
                next_state = ees_pkg::EES_WADRACK;
              end
              default: begin
                next_acking = !WP;
                next_state = ees_pkg::EES_WDACK;
                if (!WP) begin
                  // buffer the byte, count up to one page
                  f_in_valid = 1'b1;
                  if (fill != FILL_FULL) begin
                    next_fill = fill + FILL_ONE;
                  end
                end
              end
            endcase
            next_oe = next_acking;
          end
        end
        ees_pkg::EES_DEVACK, ees_pkg::EES_WADRACK, ees_pkg::EES_WDACK: begin
          // hold ack low through the ninth clock
          if (scl_fall) begin
            next_oe = 1'b0;
            if (!acking) begin
              next_state = ees_pkg::EES_WAITSTOP;
            end else if (state == ees_pkg::EES_DEVACK && rw) begin
              next_state = ees_pkg::EES_RDATA;
              next_shreg = mem[addr];
              next_oe = !mem[addr][ees_pkg::BIT_MAX];
            end else if (state == ees_pkg::EES_DEVACK) begin
              next_state = ees_pkg::EES_WADR;
            end else begin
              if (state == ees_pkg::EES_WDACK) begin
                // bump low bits only, page bits kept
                next_addr = {addr[7:4], addr[3:0] + ees_pkg::LOW_ONE};
                next_wrote = 1'b1;
              end
              next_state = ees_pkg::EES_WDATA;
            end
          end
        end
        ees_pkg::EES_RDATA: begin
          // shift out on falling clock, open drain low for zero
          if (scl_fall) begin
            if (bitc == ees_pkg::BIT_LAST) begin
              next_bitc = ees_pkg::BIT_FIRST;
              next_oe = 1'b0;
              // full counter increment, 255 wraps to 0
              next_addr = addr + ees_pkg::ADDR_ONE;
              next_state = ees_pkg::EES_RACK;
            end else begin
              next_bitc = bitc + 3'h1;
              next_shreg = {shreg[6:0], 1'b0};
              next_oe = !shreg[6];
            end
          end
        end
        ees_pkg::EES_RACK: begin
          if (scl_rise) begin
            next_acking = !BUS_IN.sda;
          end
          if (scl_fall) begin
            // next byte on master ack, else go quiet
            if (acking) begin
              next_state = ees_pkg::EES_RDATA;
              next_shreg = mem[addr];
              next_oe = !mem[addr][ees_pkg::BIT_MAX];
            end else begin
              next_state = ees_pkg::EES_WAITSTOP;
            end
          end
        end
        default: begin
          next_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ees_pkg::EES_IDLE;
      bitc <= ees_pkg::BIT_FIRST;
      shreg <= '0;
      addr <= ees_pkg::ADDR_RESET;
      page_base <= ees_pkg::ADDR_RESET;
      rw <= 1'b0;
      acking <= 1'b0;
      wrote <= 1'b0;
      oe <= 1'b0;
      full <= 1'b0;
      fill <= ees_pkg::FILL_ZERO;
    end else if (CE) begin
      state <= next_state;
      bitc <= next_bitc;
      shreg <= next_shreg;
      addr <= next_addr;
      page_base <= next_page_base;
      rw <= next_rw;
      acking <= next_acking;
      wrote <= next_wrote;
      oe <= next_oe;
      full <= next_full;
      fill <= next_fill;
    end
  end

  // Programming timer: a STOP after data starts it, supervisor reset cannot cancel it
  always_comb begin
    next_busy = busy;
    next_pcnt = pcnt;
    next_committing = committing;
    // start only on STOP after accepted data and no reset
    if (!busy && stop_c && wrote && !SUP_RESET) begin
      next_busy = 1'b1;
      next_committing = 1'b1;
      next_pcnt = ees_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
    end else if (busy) begin
      if (!f_out_valid) begin
        next_committing = 1'b0;
      end
      if (pcnt == '0) begin
        next_busy = 1'b0;
      end else begin
        next_pcnt = pcnt - ees_pkg::PROG_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      busy <= 1'b0;
      committing <= 1'b0;
      pcnt <= '0;
    end else if (CE) begin
      busy <= next_busy;
      committing <= next_committing;
      pcnt <= next_pcnt;
    end
  end

  // Array write from the buffer; last byte for an offset wins
  always_ff @(posedge MCLK) begin
    if (CE && committing && f_out_valid) begin
      mem[{page_base[7:4], fout.offs}] <= fout.data;
    end
  end

  // Open drain: output is always low, enable pulls the line
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe;
  assign BUSY = busy;

  busy_noack_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CE && busy && state == ees_pkg::EES_DEVADR && scl_fall && full)
      |=> !acking) else $error("address acknowledged while programming");
  wp_refuse_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CE && WP && state == ees_pkg::EES_WDATA && scl_fall && full
      && !SUP_RESET && !stop_c && !start_c) |=> (!oe && !acking)) else $error("protected data acknowledged");
  // page bits kept on write increment
  page_keep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CE && state == ees_pkg::EES_WDACK && next_state == ees_pkg::EES_WDATA)
      |=> addr[7:4] == $past(addr[7:4]) && addr[3:0] == $past(addr[3:0]) + 4'h1)
      else $error("page write increment wrong");
  read_inc_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (CE && state == ees_pkg::EES_RDATA && next_state == ees_pkg::EES_RACK)
      |=> addr == $past(addr) + 8'h01) else $error("read counter increment wrong");
  // no programming start under supervisor reset
  sup_block_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (SUP_RESET && !busy) |=> !busy) else $error("programming started during reset");
  // busy holds for at least eight cycles once started
  prog_len_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $rose(busy) |-> busy [*8]) else $error("programming ended too early");
  nack_quiet_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state == ees_pkg::EES_WAITSTOP) |-> !oe) else $error("driving data after nack");
  code_match_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (state == ees_pkg::EES_DEVACK && oe) |-> shreg[7:4] == DEV_CODE && !busy)
      else $error("foreign address acknowledged");
endmodule // ees_slave
`default_nettype wire

// file: testbench/ees_master.sv
// Bus master model: drives the serial clock and pulls data low, open drain
`timescale 1ns/1ps
`default_nettype none
module ees_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Every change lands by NBA at a rising edge
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put_bit(input logic b, output logic s);
    scl <= 1'b0;
    tk(2);
    sda_low <= ~b;
    tk(2);
    scl <= 1'b1;
    tk(2);
    #1 s = sda;
    tk(2);
  endtask
  task automatic start;
    scl <= 1'b0;
    tk(2);
    sda_low <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b1;
    tk(4);
  endtask
  task automatic stop;
    scl <= 1'b0;
    tk(2);
    sda_low <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b0;
    tk(4);
  endtask
  // byte out, ninth clock reads the acknowledge
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  // byte in, then acknowledge or leave it
  task automatic recv(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(~give_ack, s);
  endtask
endmodule // ees_master
`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench: slave against a reference memory model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int PROG = 150;
  // Address bytes built from the package's type code
  localparam logic [7:0] DEV_WR = {ees_pkg::DEV_CODE_RESET, 4'h0};
  localparam logic [7:0] DEV_RD = {ees_pkg::DEV_CODE_RESET, 4'h1};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic wp = 1'b0;
  logic sup_reset = 1'b0;
  logic sda_out, sda_oe, busy, m_scl, m_low, sda, ack;
  logic [7:0] d;
  ees_pkg::ees_bus_t bus_in;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 63334;
  int mem [256];
  int ptr = 0;
  // Open-drain wire, pull-up wins when nobody pulls
  assign sda = ~((sda_oe & ~sda_out) | m_low);
  assign bus_in = '{scl: m_scl, sda: sda};
  // Short programming time keeps polling loops brief
  ees_slave #(.PROG_CYCLES(PROG)) i_dut (
    .MCLK(mclk), .RST_N(rst_n), .CE(ce), .BUS_IN(bus_in), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .WP(wp), .SUP_RESET(sup_reset), .BUSY(busy));
  ees_master i_master (.clk(mclk), .sda(sda), .scl(m_scl), .sda_low(m_low));
  // 40 MHz clock
  initial forever #12.5 mclk = ~mclk;
  // Compare and count
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Start, write address, word address
  task automatic hdr(input logic [7:0] a);
    i_master.start();
    i_master.send(DEV_WR, ack);
    chk("dev ack", 8'h01, {7'h00, ack}); // address taken
    i_master.send(a, ack);
    chk("word ack", 8'h01, {7'h00, ack}); // word taken
  endtask
  // Poll until the address is taken again; bounded
  task automatic poll;
    int k;
    for (k = 0; k < 20; k++) begin
      i_master.start();
      i_master.send(DEV_WR, ack);
      i_master.stop();
      if (ack === 1'b1) break;
    end
    chk("busy polls", 8'h01, (k > 0 && k < 20) ? 8'h01 : 8'h00); // refused then taken
    if (k == 20) report_and_stop();
    chk("busy end", 8'h00, {7'h00, busy}); // cycle over
  endtask
  // Page write into design and model
  task automatic wr(input int a, input int n);
    int v;
    hdr(a[7:0]);
    for (int i = 0; i < n; i++) begin
      v = $random(seed) & 255;
      i_master.send(v[7:0], ack);
      chk("data ack", 8'h01, {7'h00, ack}); // each byte taken
      mem[(a & 8'hF0) | ((a + i) & 15)] = v;
    end
    ptr = (a & 8'hF0) | ((a + n) & 15);
    i_master.stop();
    @(negedge mclk);
    chk("busy", 8'h01, {7'h00, busy}); // one cycle starts
    @(posedge mclk);
    poll();
  endtask
  // Read n bytes from a, or from the counter when a is negative
  task automatic rd(input int a, input int n);
    if (a >= 0) begin
      hdr(a[7:0]);
      ptr = a;
    end
    i_master.start();
    i_master.send(DEV_RD, ack);
    chk("read ack", 8'h01, {7'h00, ack}); // read select
    for (int i = 0; i < n; i++) begin
      i_master.recv(i < n - 1, d);
      chk("read data", 8'(mem[ptr]), d); // next byte
      ptr = (ptr + 1) & 255;
    end
    // Lower the clock first, so a wrongly started next byte would show
    i_master.scl <= 1'b0;
    i_master.tk(2);
    @(negedge mclk);
    chk("released", 8'h00, {7'h00, sda_oe}); // quiet after nack
    @(posedge mclk);
    i_master.stop();
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    wr(8'hF0, 16);
    wr(8'h00, 16);
    wr(8'h3E, 18);
    rd(-1, 1); // counter after page write
    rd(8'h30, 16); // wrap overwrote early bytes
    rd(8'hFE, 4); // roll over top
    rd(-1, 1); // current address read
    $display("test writes and reads done");
    // Every other type code is ignored
    for (int c = 0; c < 16; c++) begin
      if (c[3:0] != ees_pkg::DEV_CODE_RESET) begin
        i_master.start();
        i_master.send({c[3:0], 4'h0}, ack);
        i_master.stop();
        chk("foreign code", 8'h00, {7'h00, ack}); // no ack
      end
    end
    $display("test type codes done");
    // Frozen block ignores a well-formed address
    ce <= 1'b0;
    i_master.start();
    i_master.send(DEV_WR, ack);
    i_master.stop();
    chk("frozen", 8'h00, {7'h00, ack}); // no ack while frozen
    ce <= 1'b1;
    i_master.tk(4);
    $display("test clock enable done");
    // Protected array keeps its content
    wp <= 1'b1;
    hdr(8'h05);
    i_master.send(8'h5A, ack);
    chk("wp data", 8'h00, {7'h00, ack}); // first data refused
    i_master.stop();
    i_master.tk(8);
    chk("wp busy", 8'h00, {7'h00, busy}); // nothing programmed
    wp <= 1'b0;
    rd(8'h05, 1); // old byte kept
    $display("test write protect done");
    // Supervisor reset refuses the bus
    sup_reset <= 1'b1;
    i_master.start();
    i_master.send(DEV_WR, ack);
    i_master.stop();
    chk("sup reset", 8'h00, {7'h00, ack}); // refused
    sup_reset <= 1'b0;
    i_master.tk(4);
    rd(8'h07, 2); // normal again
    $display("test supervisor reset done");
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
